/* File: sscr_pkg.sv */
// Purpose: constants for the static control and status register slice
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one aligned word each
// Notes:   control words carry a write mask in the upper halfword
package sscr_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 9;
  localparam int DATA_W   = 32;
  localparam int HALF_W   = 16;
  localparam int MASK_LSB = 16;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [8:0] OFS_MAC_CTRL2  = 9'h16C;
  localparam logic [8:0] OFS_TV_ENC     = 9'h170;
  localparam logic [8:0] OFS_OTG_PHY    = 9'h17C;
  localparam logic [8:0] OFS_CHARGER    = 9'h184;
  localparam logic [8:0] OFS_STRAPS_A   = 9'h188;
  localparam logic [8:0] OFS_STRAPS_B   = 9'h18C;
  localparam logic [8:0] OFS_PHY_COMMON = 9'h190;
  localparam logic [8:0] OFS_HOST_UTMI  = 9'h194;
  localparam logic [8:0] OFS_MEM_STATUS = 9'h19C;
  localparam logic [8:0] OFS_SOC_STAT2  = 9'h1A4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_MAC_CTRL2  = 16'h4040;
  localparam logic [15:0] RST_TV_ENC     = 16'h0000;
  localparam logic [15:0] RST_OTG_PHY    = 16'h0000;
  localparam logic [15:0] RST_CHARGER    = 16'h0000;
  localparam logic [15:0] RST_STRAPS_A   = 16'hC820;
  localparam logic [15:0] RST_STRAPS_B   = 16'h0B40;
  localparam logic [15:0] RST_PHY_COMMON = 16'h001C;
  localparam logic [15:0] RST_HOST_UTMI  = 16'h0000;

  // ----------------------------------------------------------------
  // implemented (writable) bits per register
  // ----------------------------------------------------------------
  localparam logic [15:0] IMP_MAC_CTRL2  = 16'h7FC0;
  localparam logic [15:0] IMP_TV_ENC     = 16'h1FFF;
  localparam logic [15:0] IMP_OTG_PHY    = 16'h003F;
  localparam logic [15:0] IMP_CHARGER    = 16'h1F80;
  localparam logic [15:0] IMP_STRAPS_A   = 16'hFFFF;
  localparam logic [15:0] IMP_STRAPS_B   = 16'hEF41;
  localparam logic [15:0] IMP_PHY_COMMON = 16'hBCFF;
  localparam logic [15:0] IMP_HOST_UTMI  = 16'h41FF;

  // ----------------------------------------------------------------
  // field positions and encodings
  // ----------------------------------------------------------------
  localparam int         MAC_INTF_LSB   = 6;
  localparam int         MAC_INTF_MSB   = 8;
  localparam logic [15:0] MAC_INTF_FIELD = 16'h01C0;
  localparam logic [2:0] INTF_RGMII     = 3'h1;
  localparam logic [2:0] INTF_RMII      = 3'h4;
  localparam int         UTMI_PEND_BIT  = 15;
  localparam int         UTMI_IRQ_EN    = 14;
  localparam int         MEM_STATE_LSB  = 16;
  localparam int         MEM_STATE_MSB  = 18;
  localparam int         GPU_IDLE_W     = 11;
  localparam int         SOC_STAT2_W    = 11;

endpackage

/* File: sscr_mreg.sv */
// Purpose: one masked-write control halfword
// Assumes: bit_en_in already combines mask halfword and byte lanes
// Notes:   unimplemented bits are constant zero
`timescale 1ns/1ps
module sscr_mreg #(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] IMPL      = 16'hFFFF
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // write port
  input  wire logic        we_in,
  input  wire logic [15:0] bit_en_in,
  input  wire logic [15:0] data_in,
  // value
  output logic      [15:0] value_out
);

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_bit
      if (IMPL[g]) begin : g_impl
        always_ff @(posedge clk_in) begin
          if (!reset_n_in) begin
            value_out[g] <= RESET_VAL[g];
          end else if (we_in && bit_en_in[g]) begin
            value_out[g] <= data_in[g];
          end
        end
      end else begin : g_rsvd
        assign value_out[g] = 1'b0;
      end
    end
  endgenerate

endmodule // sscr_mreg

/* File: sscr_regs.sv */
// Purpose: static control straps and status readback over Avalon-MM
// Assumes: status inputs come from logic on clk_in; line state is async
// Notes:   each access answers on the second edge after it is raised
`timescale 1ns/1ps
module sscr_regs (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // avalon-mm slave
  input  wire logic [8:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // memory controller and soc status
  input  wire logic [15:0] mem_bank_busy_in,
  input  wire logic [2:0]  mem_ctrl_state_in,
  input  wire logic        mem_lp_accept_in,
  input  wire logic        mem_lp_response_in,
  input  wire logic [10:0] gpu_idle_in,
  input  wire logic [10:0] soc_status_second_in,
  // asynchronous line state change from the phy
  input  wire logic        line_state_event_in,
  // control straps
  output logic      [15:0] mac_control_out,
  output logic      [15:0] tv_encoder_out,
  output logic      [15:0] otg_phy_out,
  output logic      [15:0] charger_out,
  output logic      [15:0] host_straps_a_out,
  output logic      [15:0] host_straps_b_out,
  output logic      [15:0] phy_common_out,
  output logic      [15:0] host_utmi_out
);

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic        req;
  logic        wr_take;
  logic [15:0] wen16;
  logic [15:0] mac_en;
  logic [15:0] utmi_val;
  logic        pend_q;

  assign req     = avs_read_in | avs_write_in;
  assign wr_take = avs_write_in & ~wait_q;
  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out    = rdata_q;

  // one wait cycle gives a registered read mux without a combinational
  // path from address to readdata
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wait_q <= 1'b1;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (req && wait_q) begin
      rdata_q <= avs_read_in ? rd_mux : 32'h0000_0000;
    end
  end

  // a bit changes only if its mask bit and both byte lanes are enabled
  assign wen16 = avs_writedata_in[31:16] &
                 {{8{avs_byteenable_in[3] & avs_byteenable_in[1]}},
                  {8{avs_byteenable_in[2] & avs_byteenable_in[0]}}};

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [2:0] new_intf;
  logic [2:0] intf_keep;
  logic [2:0] intf_wen;
  logic       intf_bad;

  // judge the merged field: a partial mask must not build a reserved code
  assign intf_keep = mac_control_out[sscr_pkg::MAC_INTF_MSB:
                                     sscr_pkg::MAC_INTF_LSB];
  assign intf_wen  = wen16[sscr_pkg::MAC_INTF_MSB:sscr_pkg::MAC_INTF_LSB];
  assign new_intf  = (intf_keep & ~intf_wen) |
                     (avs_writedata_in[sscr_pkg::MAC_INTF_MSB:
                                       sscr_pkg::MAC_INTF_LSB] & intf_wen);
  // reserved interface codes are dropped so the mac never sees one
  assign intf_bad = (new_intf != sscr_pkg::INTF_RGMII) &&
                    (new_intf != sscr_pkg::INTF_RMII);
  assign mac_en   = intf_bad ? (wen16 & ~sscr_pkg::MAC_INTF_FIELD)
                             : wen16;

  sscr_mreg #(
    .RESET_VAL (sscr_pkg::RST_MAC_CTRL2),
    .IMPL      (sscr_pkg::IMP_MAC_CTRL2)
  ) u_mac (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .we_in      (wr_take && avs_address_in == sscr_pkg::OFS_MAC_CTRL2),
    .bit_en_in  (mac_en),
    .data_in    (avs_writedata_in[15:0]),
    .value_out  (mac_control_out)
  );

  sscr_mreg #(
    .RESET_VAL (sscr_pkg::RST_TV_ENC),
    .IMPL      (sscr_pkg::IMP_TV_ENC)
  ) u_tve (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .we_in      (wr_take && avs_address_in == sscr_pkg::OFS_TV_ENC),
    .bit_en_in  (wen16),
    .data_in    (avs_writedata_in[15:0]),
    .value_out  (tv_encoder_out)
  );

  sscr_mreg #(
    .RESET_VAL (sscr_pkg::RST_OTG_PHY),
    .IMPL      (sscr_pkg::IMP_OTG_PHY)
  ) u_otg (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .we_in      (wr_take && avs_address_in == sscr_pkg::OFS_OTG_PHY),
    .bit_en_in  (wen16),
    .data_in    (avs_writedata_in[15:0]),
    .value_out  (otg_phy_out)
  );

  sscr_mreg #(
    .RESET_VAL (sscr_pkg::RST_CHARGER),
    .IMPL      (sscr_pkg::IMP_CHARGER)
  ) u_chg (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .we_in      (wr_take && avs_address_in == sscr_pkg::OFS_CHARGER),
    .bit_en_in  (wen16),
    .data_in    (avs_writedata_in[15:0]),
    .value_out  (charger_out)
  );

  sscr_mreg #(
    .RESET_VAL (sscr_pkg::RST_STRAPS_A),
    .IMPL      (sscr_pkg::IMP_STRAPS_A)
  ) u_sta (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .we_in      (wr_take && avs_address_in == sscr_pkg::OFS_STRAPS_A),
    .bit_en_in  (wen16),
    .data_in    (avs_writedata_in[15:0]),
    .value_out  (host_straps_a_out)
  );

  sscr_mreg #(
    .RESET_VAL (sscr_pkg::RST_STRAPS_B),
    .IMPL      (sscr_pkg::IMP_STRAPS_B)
  ) u_stb (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .we_in      (wr_take && avs_address_in == sscr_pkg::OFS_STRAPS_B),
    .bit_en_in  (wen16),
    .data_in    (avs_writedata_in[15:0]),
    .value_out  (host_straps_b_out)
  );

  sscr_mreg #(
    .RESET_VAL (sscr_pkg::RST_PHY_COMMON),
    .IMPL      (sscr_pkg::IMP_PHY_COMMON)
  ) u_com (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .we_in      (wr_take && avs_address_in == sscr_pkg::OFS_PHY_COMMON),
    .bit_en_in  (wen16),
    .data_in    (avs_writedata_in[15:0]),
    .value_out  (phy_common_out)
  );

  sscr_mreg #(
    .RESET_VAL (sscr_pkg::RST_HOST_UTMI),
    .IMPL      (sscr_pkg::IMP_HOST_UTMI)
  ) u_utm (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .we_in      (wr_take && avs_address_in == sscr_pkg::OFS_HOST_UTMI),
    .bit_en_in  (wen16),
    .data_in    (avs_writedata_in[15:0]),
    .value_out  (utmi_val)
  );

  // ----------------------------------------------------------------
  // line state pending flag
  // ----------------------------------------------------------------
  logic ls_meta_q;
  logic ls_sync_q;
  logic ls_prev_q;
  logic ls_rise;
  logic pend_clr;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ls_meta_q <= 1'b0;
      ls_sync_q <= 1'b0;
      ls_prev_q <= 1'b0;
    end else begin
      ls_meta_q <= line_state_event_in;
      ls_sync_q <= ls_meta_q;
      ls_prev_q <= ls_sync_q;
    end
  end

  assign ls_rise  = ls_sync_q & ~ls_prev_q;
  assign pend_clr = wr_take &&
                    avs_address_in == sscr_pkg::OFS_HOST_UTMI &&
                    wen16[sscr_pkg::UTMI_PEND_BIT] &&
                    avs_writedata_in[sscr_pkg::UTMI_PEND_BIT];

  // a change arriving with the clearing write keeps the flag set
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pend_q <= 1'b0;
    end else if (ls_rise) begin
      pend_q <= 1'b1;
    end else if (pend_clr) begin
      pend_q <= 1'b0;
    end
  end

  assign host_utmi_out = {pend_q, utmi_val[14:0]};

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address_in == sscr_pkg::OFS_MAC_CTRL2) begin
      rd_mux[15:0] = mac_control_out;
    end else if (avs_address_in == sscr_pkg::OFS_TV_ENC) begin
      rd_mux[15:0] = tv_encoder_out;
    end else if (avs_address_in == sscr_pkg::OFS_OTG_PHY) begin
      rd_mux[15:0] = otg_phy_out;
    end else if (avs_address_in == sscr_pkg::OFS_CHARGER) begin
      rd_mux[15:0] = charger_out;
    end else if (avs_address_in == sscr_pkg::OFS_STRAPS_A) begin
      rd_mux[15:0] = host_straps_a_out;
    end else if (avs_address_in == sscr_pkg::OFS_STRAPS_B) begin
      rd_mux[15:0] = host_straps_b_out;
    end else if (avs_address_in == sscr_pkg::OFS_PHY_COMMON) begin
      rd_mux[15:0] = phy_common_out;
    end else if (avs_address_in == sscr_pkg::OFS_HOST_UTMI) begin
      rd_mux[15:0] = host_utmi_out;
    end else if (avs_address_in == sscr_pkg::OFS_MEM_STATUS) begin
      rd_mux = {gpu_idle_in, mem_lp_accept_in, mem_lp_response_in,
                mem_ctrl_state_in, mem_bank_busy_in};
    end else if (avs_address_in == sscr_pkg::OFS_SOC_STAT2) begin
      rd_mux[10:0] = soc_status_second_in;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  logic tve_wr;
  assign tve_wr = wr_take && avs_address_in == sscr_pkg::OFS_TV_ENC;

  a_mask_keeps: assert property (
    tve_wr && !avs_writedata_in[16] && avs_byteenable_in == 4'hF
    |=> tv_encoder_out[0] == $past(tv_encoder_out[0]))
    else $error("masked bit changed");
  a_mask_writes: assert property (
    tve_wr && avs_writedata_in[16] && avs_byteenable_in == 4'hF
    |=> tv_encoder_out[0] == $past(avs_writedata_in[0]))
    else $error("enabled bit not written");
  a_intf_legal: assert property (
    mac_control_out[8:6] == sscr_pkg::INTF_RGMII ||
    mac_control_out[8:6] == sscr_pkg::INTF_RMII)
    else $error("reserved phy interface code");
  a_wait_answer: assert property (
    req && wait_q |=> !wait_q ##1 wait_q)
    else $error("answer not one cycle");
  a_pend_sets: assert property (
    ls_rise |=> pend_q && host_utmi_out[15])
    else $error("pending flag not set");
  a_pend_clears: assert property (
    pend_clr && !ls_rise |=> !pend_q)
    else $error("pending flag not cleared");
  a_mem_state: assert property (
    avs_read_in && wait_q && avs_address_in == sscr_pkg::OFS_MEM_STATUS
    |=> avs_readdata_out[18:16] == $past(mem_ctrl_state_in) &&
        avs_readdata_out[15:0] == $past(mem_bank_busy_in))
    else $error("memory status readback wrong");
  a_rsvd_zero: assert property (
    avs_read_in && wait_q && avs_address_in == sscr_pkg::OFS_TV_ENC
    |=> avs_readdata_out[31:13] == 19'h00000)
    else $error("reserved bits not zero");
  a_straps_reset: assert property (
    !$past(reset_n_in) |-> host_straps_a_out == sscr_pkg::RST_STRAPS_A &&
                           host_straps_b_out == sscr_pkg::RST_STRAPS_B)
    else $error("strap reset value wrong");
  a_intf_kept: assert property (
    wr_take && avs_address_in == sscr_pkg::OFS_MAC_CTRL2 && intf_bad
    |=> $stable(mac_control_out[8:6]))
    else $error("reserved interface code taken");
  a_pend_race: assert property (
    ls_rise && pend_clr |=> pend_q)
    else $error("pending set lost to clear");
  a_idle_wait: assert property (
    !req |=> avs_waitrequest_out)
    else $error("waitrequest low without request");
  a_mask_zero: assert property (
    avs_read_in && wait_q && avs_address_in != sscr_pkg::OFS_MEM_STATUS
    |=> avs_readdata_out[31:16] == 16'h0000)
    else $error("upper halfword not zero");
  a_lp_status: assert property (
    avs_read_in && wait_q && avs_address_in == sscr_pkg::OFS_MEM_STATUS
    |=> avs_readdata_out[31:21] == $past(gpu_idle_in) &&
        avs_readdata_out[20] == $past(mem_lp_accept_in) &&
        avs_readdata_out[19] == $past(mem_lp_response_in))
    else $error("idle and low-power bits wrong");
  a_soc_status: assert property (
    avs_read_in && wait_q && avs_address_in == sscr_pkg::OFS_SOC_STAT2
    |=> avs_readdata_out == {21'h000000, $past(soc_status_second_in)})
    else $error("second status word wrong");
  a_wr_lands: assert property (
    wr_take && avs_address_in == sscr_pkg::OFS_STRAPS_A &&
    avs_byteenable_in == 4'hF && avs_writedata_in[31]
    |=> host_straps_a_out[15] == $past(avs_writedata_in[15]))
    else $error("strap write lost");

  // ----------------------------------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------------------------------
  c_read_done: cover property (avs_read_in && !wait_q);
  c_write_done: cover property (wr_take && wen16 != 16'h0000);
  c_pend_race: cover property (ls_rise && pend_clr);
  c_intf_reject: cover property (
    wr_take && avs_address_in == sscr_pkg::OFS_MAC_CTRL2 && intf_bad);
  c_pend_clear: cover property (pend_clr && pend_q);

endmodule // sscr_regs

/* File: sscr_regs_bench.sv */
// Purpose: self-checking bench for the static control register slice
// Assumes: avalon-mm slave with one wait cycle, 25 MHz clock
// Notes:   a shadow model predicts every control word from the writes
`timescale 1ns/1ps
module sscr_regs_bench;

  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic        clk_in;
  logic        reset_n_in;
  logic [8:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [15:0] mem_bank_busy_in;
  logic [2:0]  mem_ctrl_state_in;
  logic        mem_lp_accept_in;
  logic        mem_lp_response_in;
  logic [10:0] gpu_idle_in;
  logic [10:0] soc_status_second_in;
  logic        line_state_event_in;
  logic [15:0] mac_control_out;
  logic [15:0] tv_encoder_out;
  logic [15:0] otg_phy_out;
  logic [15:0] charger_out;
  logic [15:0] host_straps_a_out;
  logic [15:0] host_straps_b_out;
  logic [15:0] phy_common_out;
  logic [15:0] host_utmi_out;
  logic [8:0]  reg_ofs [8];
  logic [15:0] reg_rst [8];
  logic [15:0] reg_imp [8];
  logic [15:0] shadow  [8];
  logic [31:0] rd;
  int          mismatches;
  int          cmp_count;
  int          cycles;

  sscr_regs DUT (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .mem_bank_busy_in(mem_bank_busy_in),
    .mem_ctrl_state_in(mem_ctrl_state_in),
    .mem_lp_accept_in(mem_lp_accept_in),
    .mem_lp_response_in(mem_lp_response_in),
    .gpu_idle_in(gpu_idle_in), .soc_status_second_in(soc_status_second_in),
    .line_state_event_in(line_state_event_in),
    .mac_control_out(mac_control_out), .tv_encoder_out(tv_encoder_out),
    .otg_phy_out(otg_phy_out), .charger_out(charger_out),
    .host_straps_a_out(host_straps_a_out),
    .host_straps_b_out(host_straps_b_out),
    .phy_common_out(phy_common_out), .host_utmi_out(host_utmi_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // bench cannot hang: the whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("[ERR] %0t run did not finish", $time);
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // bus access and shadow model
  // ----------------------------------------------------------------
  // entered right after a rising edge; leaves one idle cycle behind
  task automatic bus_xfer(input logic wr, input logic [8:0] a,
                          input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address_in    <= a;
    avs_writedata_in  <= d;
    avs_byteenable_in <= be;
    avs_write_in      <= wr;
    avs_read_in       <= ~wr;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0) begin
      @(posedge clk_in);
      n++;
    end
    rd = avs_readdata_out;
    check(n, 32'h1, "answer latency");
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
    bus_xfer(1'b0, a, 32'h0, 4'hF);
    check(rd, exp, "read data");
  endtask

  function automatic logic [15:0] out_of(input int i);
    case (i)
      0: return mac_control_out;
      1: return tv_encoder_out;
      2: return otg_phy_out;
      3: return charger_out;
      4: return host_straps_a_out;
      5: return host_straps_b_out;
      6: return phy_common_out;
      default: return host_utmi_out;
    endcase
  endfunction

  task automatic wr_model(input int i, input logic [31:0] d,
                          input logic [3:0] be);
    logic [15:0] m;
    logic [15:0] nv;
    m  = d[31:16] & {{8{be[3] & be[1]}}, {8{be[2] & be[0]}}};
    nv = (shadow[i] & ~(m & reg_imp[i])) | (d[15:0] & m & reg_imp[i]);
    if (i == 0 && nv[8:6] != 3'h1 && nv[8:6] != 3'h4)
      nv[8:6] = shadow[i][8:6];
    if (i == 7 && m[15] && d[15])
      nv[15] = 1'b0;
    shadow[i] = nv;
    bus_xfer(1'b1, reg_ofs[i], d, be);
    rd_chk(reg_ofs[i], {16'h0, shadow[i]});
    check({16'h0, out_of(i)}, {16'h0, shadow[i]}, "strap output");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reg_ofs = '{sscr_pkg::OFS_MAC_CTRL2, sscr_pkg::OFS_TV_ENC,
                sscr_pkg::OFS_OTG_PHY, sscr_pkg::OFS_CHARGER,
                sscr_pkg::OFS_STRAPS_A, sscr_pkg::OFS_STRAPS_B,
                sscr_pkg::OFS_PHY_COMMON, sscr_pkg::OFS_HOST_UTMI};
    reg_rst = '{16'h4040, 16'h0000, 16'h0000, 16'h0000,
                16'hC820, 16'h0B40, 16'h001C, 16'h0000};
    reg_imp = '{16'h7FC0, 16'h1FFF, 16'h003F, 16'h1F80,
                16'hFFFF, 16'hEF41, 16'hBCFF, 16'h41FF};
    mismatches = 0;
    cmp_count  = 0;
    cycles     = 0;
    reset_n_in = 1'b0;
    {avs_read_in, avs_write_in} = 2'b00;
    avs_address_in       = 9'h000;
    avs_writedata_in     = 32'h0;
    avs_byteenable_in    = 4'hF;
    {mem_bank_busy_in, mem_ctrl_state_in} = 19'h0;
    {mem_lp_accept_in, mem_lp_response_in} = 2'b00;
    gpu_idle_in          = 11'h000;
    soc_status_second_in = 11'h000;
    line_state_event_in  = 1'b0;
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    check({31'h0, avs_waitrequest_out}, 32'h1, "idle waitrequest");
    for (int i = 0; i < 8; i++) begin
      shadow[i] = reg_rst[i];
      rd_chk(reg_ofs[i], {16'h0, reg_rst[i]});
      check({16'h0, out_of(i)}, {16'h0, reg_rst[i]}, "reset strap");
    end
    $display("test reset values done");
    // masked writes, per-bit gating and byte lanes on every control word
    for (int i = 0; i < 8; i++) begin
      wr_model(i, 32'hFFFF_FFFF, 4'hF);
      wr_model(i, 32'h0000_0000, 4'hF);
      wr_model(i, 32'h5555_0000, 4'hF);
      wr_model(i, 32'hFFFF_0000, 4'hF);
      wr_model(i, 32'hFFFF_FFFF, 4'h5);
    end
    $display("test masked writes done");
    for (int c = 0; c < 8; c++)
      wr_model(0, {16'h01C0, 7'h0, c[2:0], 6'h0}, 4'hF);
    for (int c = 0; c < 16; c++) begin
      wr_model(2, {16'h003C, 10'h0, c[3:0], 2'h0}, 4'hF);
      wr_model(7, {16'h003C, 10'h0, c[3:0], 2'h0}, 4'hF);
    end
    $display("test field codes done");
    // status words follow their inputs; the memory status word ignores writes
    for (int s = 0; s < 8; s++) begin
      mem_ctrl_state_in    <= s[2:0];
      mem_bank_busy_in     <= 16'h8001 >> s;
      gpu_idle_in          <= 11'h5A5 >> s;
      mem_lp_accept_in     <= s[0];
      mem_lp_response_in   <= s[1];
      soc_status_second_in <= 11'h400 | 11'(s);
      bus_xfer(1'b1, sscr_pkg::OFS_MEM_STATUS, 32'hFFFF_FFFF, 4'hF);
      rd_chk(sscr_pkg::OFS_MEM_STATUS, {11'h5A5 >> s, s[0], s[1], s[2:0],
             16'h8001 >> s});
      rd_chk(sscr_pkg::OFS_SOC_STAT2, {21'h0, 11'h400 | 11'(s)});
    end
    $display("test status words done");
    bus_xfer(1'b1, 9'h174, 32'hFFFF_FFFF, 4'hF);
    rd_chk(9'h174, 32'h0);
    rd_chk(9'h16E, 32'h0);
    rd_chk(reg_ofs[1], {16'h0, shadow[1]});
    $display("test unmapped done");
    // line-state pending: set by an event, cleared only by masked one
    line_state_event_in <= 1'b1;
    for (int n = 0; n < 10 && host_utmi_out[15] !== 1'b1; n++)
      @(posedge clk_in);
    line_state_event_in <= 1'b0;
    shadow[7][15] = 1'b1;
    wr_model(7, 32'h0000_8000, 4'hF);
    wr_model(7, 32'h8000_0000, 4'hF);
    wr_model(7, 32'hC000_C000, 4'hF);
    $display("test line state done");
    // a second reset mid-run brings every strap back
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      shadow[i] = reg_rst[i];
      check({16'h0, out_of(i)}, {16'h0, reg_rst[i]}, "strap after reset");
      rd_chk(reg_ofs[i], {16'h0, reg_rst[i]});
    end
    $display("test second reset done");
    end_of_test();
  end

endmodule // sscr_regs_bench
